// >>> rtl/watchdog_pkg.sv
package watchdog_pkg;

    // Register byte offsets
    localparam logic [11:0] COUNT_OFS   = 12'h000;
    localparam logic [11:0] RELOAD_OFS  = 12'h004;
    localparam logic [11:0] RESTART_OFS = 12'h008;
    localparam logic [11:0] CONTROL_OFS = 12'h00c;
    localparam logic [11:0] STATUS_OFS  = 12'h010;
    localparam logic [11:0] CLEAR_OFS   = 12'h014;
    localparam logic [11:0] PLEN_OFS    = 12'h018;
    localparam logic [11:0] REV_OFS     = 12'h01c;

    // Reset values and key
    localparam logic [31:0] RELOAD_RESET  = 32'h03ef_1480;
    localparam logic [15:0] RESTART_KEY   = 16'h5ab9;
    localparam logic [7:0]  PLEN_RESET    = 8'hff;
    localparam logic [4:0]  CONTROL_RESET = 5'h00;

    // Control field positions
    localparam int COUNTDOWN_ENABLE_BIT        = 0;
    localparam int SYSTEM_RESET_ENABLE_BIT     = 1;
    localparam int SYSTEM_INTERRUPT_ENABLE_BIT = 2;
    localparam int EXTERNAL_SIGNAL_ENABLE_BIT  = 3;
    localparam int COUNT_CLOCK_SELECT_BIT      = 4;

    // Whole state of the watchdog
    typedef struct packed {
        logic [31:0] count;
        logic [31:0] reload;
        logic [15:0] restart_key;
        logic [4:0]  watchdog_control;
        logic        expiry_flag;
        logic [7:0]  pulse_length;
        logic [7:0]  pulse_cnt;
        logic        pulse_on;
        logic        fired;
        logic [2:0]  ext_sync;
        logic [31:0] prdata;
        logic        pslverr;
    } wdog_state_t;

    // Expiry outputs travel together
    typedef struct packed {
        logic reset_out;
        logic interrupt_out;
        logic external_out;
    } expiry_out_t;

endpackage : watchdog_pkg

// >>> rtl/watchdog_timer.sv
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer
    import watchdog_pkg::*;
#(
    parameter logic [31:0] REVISION = 32'h0000_0001 // Arbitrary value
) (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        external_count_clock,
    output logic             expiry_reset_out,
    output logic             expiry_interrupt_out,
    output logic             expiry_external_out
);

    // Hit test on a word-aligned offset, shared by read and write decode
    function automatic logic reg_hit(input logic [11:0] a,
                                     input logic [11:0] ofs);
        reg_hit = (a == ofs);
    endfunction : reg_hit

    // Elaboration checks: the key register idles at zero, so a zero key
    // would restart the counter on every cycle
    if (RESTART_KEY == 16'h0000) begin : key_check_g
        $error("restart key must differ from zero");
    end

    // The decode compares whole byte offsets; each register needs a word
    if (((COUNT_OFS | RELOAD_OFS | RESTART_OFS | CONTROL_OFS
          | STATUS_OFS | CLEAR_OFS | PLEN_OFS
          | REV_OFS) & 12'h003) != 12'h000) begin : align_check_g
        $error("register offsets must be word aligned");
    end

    // The control register is five bits wide; every field must fit
    if (COUNT_CLOCK_SELECT_BIT > 4 || EXTERNAL_SIGNAL_ENABLE_BIT > 4
        || SYSTEM_INTERRUPT_ENABLE_BIT > 4 || SYSTEM_RESET_ENABLE_BIT > 4
        || COUNTDOWN_ENABLE_BIT > 4) begin : field_check_g
        $error("control field outside the control register");
    end

    wdog_state_t st;
    wdog_state_t next_st;
    expiry_out_t outs;

    logic wr_acc;
    logic rd_setup;
    logic ext_rise;
    logic tick;
    logic expire;
    logic key_ok;
    logic mapped;

    // Bus strobes and count tick
    always_comb begin
        wr_acc   = psel && penable && pwrite;
        rd_setup = psel && !penable && !pwrite;
        // Only the second and third sync stages are looked at
        ext_rise = st.ext_sync[1] && !st.ext_sync[2];
        tick     = st.watchdog_control[COUNT_CLOCK_SELECT_BIT] ? ext_rise
                                                               : 1'b1;
        key_ok   = (st.restart_key == RESTART_KEY);
        expire   = st.watchdog_control[COUNTDOWN_ENABLE_BIT] && !st.fired
                   && (st.count == 32'h0000_0000) && !key_ok;
        mapped   = reg_hit(paddr, COUNT_OFS) || reg_hit(paddr, RELOAD_OFS)
                   || reg_hit(paddr, RESTART_OFS)
                   || reg_hit(paddr, CONTROL_OFS)
                   || reg_hit(paddr, STATUS_OFS) || reg_hit(paddr, CLEAR_OFS)
                   || reg_hit(paddr, PLEN_OFS) || reg_hit(paddr, REV_OFS);
    end

    // Next state
    always_comb begin
        next_st = st;
        next_st.ext_sync = {st.ext_sync[1:0], external_count_clock};
        // Key lives one cycle, then reads back as zero
        next_st.restart_key = 16'h0000;
        if (wr_acc && reg_hit(paddr, RESTART_OFS)) begin
            next_st.restart_key = pwdata[15:0];
        end
        if (wr_acc && reg_hit(paddr, RELOAD_OFS)) begin
            next_st.reload = pwdata;
        end
        if (wr_acc && reg_hit(paddr, CONTROL_OFS)) begin
            next_st.watchdog_control = pwdata[4:0];
        end
        if (wr_acc && reg_hit(paddr, PLEN_OFS)) begin
            next_st.pulse_length = pwdata[7:0];
        end
        // Countdown; any other key value is simply ignored
        if (key_ok) begin
            next_st.count = st.reload;
            next_st.fired = 1'b0;
        end else if (st.watchdog_control[COUNTDOWN_ENABLE_BIT] && tick
                     && st.count != 32'h0000_0000) begin
            next_st.count = st.count - 32'h0000_0001;
        end
        // Clear first so that a same-cycle expiry wins
        if (wr_acc && reg_hit(paddr, CLEAR_OFS) && pwdata[0]) begin
            next_st.expiry_flag = 1'b0;
        end
        // Pulse runs pulse_length + 1 cycles
        if (st.pulse_on) begin
            if (st.pulse_cnt == 8'h00) begin
                next_st.pulse_on = 1'b0;
            end else begin
                next_st.pulse_cnt = st.pulse_cnt - 8'h01;
            end
        end
        // Fires once at zero, then waits for a restart
        if (expire) begin
            next_st.fired       = 1'b1;
            next_st.expiry_flag = 1'b1;
            next_st.pulse_on    = 1'b1;
            next_st.pulse_cnt   = st.pulse_length;
        end
        // Read data is fetched in setup so it stands during access
        if (rd_setup) begin
            next_st.prdata = 32'h0000_0000;
            if (reg_hit(paddr, COUNT_OFS)) begin
                next_st.prdata = st.count;
            end
            if (reg_hit(paddr, RELOAD_OFS)) begin
                next_st.prdata = st.reload;
            end
            if (reg_hit(paddr, CONTROL_OFS)) begin
                next_st.prdata = {27'h000_0000, st.watchdog_control};
            end
            if (reg_hit(paddr, STATUS_OFS)) begin
                next_st.prdata = {31'h0000_0000, st.expiry_flag};
            end
            if (reg_hit(paddr, PLEN_OFS)) begin
                next_st.prdata = {24'h00_0000, st.pulse_length};
            end
            if (reg_hit(paddr, REV_OFS)) begin
                next_st.prdata = REVISION;
            end
        end
        if (psel && !penable) begin
            next_st.pslverr = !mapped;
        end
    end

    // State register; clock enable low freezes everything, but srst still loads the reset values
    always_ff @(posedge clk) begin
        if (srst) begin
            st                  <= '0;
            st.count            <= RELOAD_RESET;
            st.reload           <= RELOAD_RESET;
            st.watchdog_control <= CONTROL_RESET;
            st.pulse_length     <= PLEN_RESET;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // Outputs gated by their enables
    always_comb begin
        outs.reset_out     = st.pulse_on
            && st.watchdog_control[SYSTEM_RESET_ENABLE_BIT];
        outs.interrupt_out = st.pulse_on
            && st.watchdog_control[SYSTEM_INTERRUPT_ENABLE_BIT];
        outs.external_out  = st.pulse_on
            && st.watchdog_control[EXTERNAL_SIGNAL_ENABLE_BIT];
    end

    assign expiry_reset_out     = outs.reset_out;
    assign expiry_interrupt_out = outs.interrupt_out;
    assign expiry_external_out  = outs.external_out;
    assign prdata               = st.prdata;
    assign pslverr              = st.pslverr && psel && penable;
    assign pready               = 1'b1; // Zero wait states

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // Restart loads the reload value
    restart_load_a: assert property (
        ce && key_ok |=> st.count == $past(st.reload))
        else $error("restart did not reload counter");

    // A restart also re-arms the single expiry shot
    restart_rearm_a: assert property (
        ce && key_ok |=> !st.fired)
        else $error("restart did not re-arm expiry");

    // Reset loads the default into both count and reload, ce or not
    reset_load_a: assert property (
        disable iff (1'b0) srst |=> st.count == RELOAD_RESET
            && st.reload == RELOAD_RESET)
        else $error("reset did not load default count");

    // A committed write lands in the key register for one cycle
    key_store_a: assert property (
        ce && wr_acc && reg_hit(paddr, RESTART_OFS)
        |=> st.restart_key == $past(pwdata[15:0]))
        else $error("restart key write lost");

    // Key register self-clears after one cycle
    key_clear_a: assert property (
        ce && st.restart_key != 16'h0000 && !(wr_acc
            && reg_hit(paddr, RESTART_OFS)) |=> st.restart_key == 16'h0000)
        else $error("restart key not self-cleared");

    // Disabled counter holds its value
    hold_disabled_a: assert property (
        ce && !st.watchdog_control[COUNTDOWN_ENABLE_BIT] && !key_ok
        |=> $stable(st.count))
        else $error("counter moved while disabled");

    // Bus clock mode takes one off every enabled cycle
    bus_clock_dec_a: assert property (
        ce && st.watchdog_control[COUNTDOWN_ENABLE_BIT]
        && !st.watchdog_control[COUNT_CLOCK_SELECT_BIT]
        && st.count != 32'h0000_0000 && !key_ok
        |=> st.count == $past(st.count) - 32'h0000_0001)
        else $error("counter did not decrement on bus clock");

    // External mode moves only on a synchronised rising edge
    ext_hold_a: assert property (
        ce && st.watchdog_control[COUNT_CLOCK_SELECT_BIT] && !ext_rise
        && !key_ok |=> $stable(st.count))
        else $error("counter moved without external edge");

    // Expiry raises the flag and starts a full-length pulse
    expiry_fire_a: assert property (
        ce && expire |=> st.expiry_flag && st.pulse_on
            && st.pulse_cnt == $past(st.pulse_length))
        else $error("expiry did not fire");

    // Pulses start only from an expiry
    pulse_start_a: assert property (
        ce && !st.pulse_on && !expire |=> !st.pulse_on)
        else $error("pulse started without expiry");

    // A disabled output never shows, whatever the pulse does
    reset_gate_a: assert property (
        !st.watchdog_control[SYSTEM_RESET_ENABLE_BIT]
        |-> !expiry_reset_out)
        else $error("reset output while disabled");

    intr_gate_a: assert property (
        !st.watchdog_control[SYSTEM_INTERRUPT_ENABLE_BIT]
        |-> !expiry_interrupt_out)
        else $error("interrupt output while disabled");

    ext_gate_a: assert property (
        !st.watchdog_control[EXTERNAL_SIGNAL_ENABLE_BIT]
        |-> !expiry_external_out)
        else $error("external output while disabled");

    // Pulse ends after its last counted cycle
    pulse_end_a: assert property (
        ce && st.pulse_on && st.pulse_cnt == 8'h00 && !expire
        |=> !st.pulse_on)
        else $error("pulse overran its length");

    // Each pulse cycle takes one off the remaining length
    pulse_count_a: assert property (
        ce && st.pulse_on && st.pulse_cnt != 8'h00 && !expire
        |=> st.pulse_on && st.pulse_cnt == $past(st.pulse_cnt) - 8'h01)
        else $error("pulse length count slipped");

    // A one written to the clear register drops the flag
    status_clear_a: assert property (
        ce && wr_acc && reg_hit(paddr, CLEAR_OFS) && pwdata[0] && !expire
        |=> !st.expiry_flag)
        else $error("status not cleared");

    // Without a clear the flag stays up
    flag_keep_a: assert property (
        ce && st.expiry_flag
        && !(wr_acc && reg_hit(paddr, CLEAR_OFS) && pwdata[0])
        |=> st.expiry_flag)
        else $error("status dropped without clear");

    // The flag rises only at an expiry
    flag_rise_a: assert property (
        ce && !st.expiry_flag && !expire |=> !st.expiry_flag)
        else $error("status set without expiry");

    // Zero is sticky until a key arrives
    zero_hold_a: assert property (
        ce && st.count == 32'h0000_0000 && !key_ok
        |=> st.count == 32'h0000_0000)
        else $error("counter left zero without restart");

    // Once fired, no second shot until a restart re-arms it
    fire_once_a: assert property (
        ce && st.fired && !key_ok |=> !expire)
        else $error("expiry fired twice");

    // Any other key value leaves the counter alone
    wrong_key_a: assert property (
        ce && st.restart_key != 16'h0000 && !key_ok
        && !st.watchdog_control[COUNTDOWN_ENABLE_BIT] |=> $stable(st.count))
        else $error("wrong key changed counter");

endmodule : watchdog_timer
`default_nettype wire

// >>> verification/expiry_partner.sv
`timescale 1ns/1ps
`default_nettype none
module expiry_partner
    import watchdog_pkg::*;
(
    input  wire logic        clk,
    input  wire expiry_out_t outs,
    output logic             ext_clk
);
    int pulses [3];
    int width  [3];
    int run    [3];

    // Measure every expiry pulse mid-cycle, where the outputs are settled
    always @(negedge clk) begin
        for (int i = 0; i < 3; i++) begin
            if (outs[i] === 1'b1) begin
                run[i]++;
            end else if (run[i] > 0) begin
                width[i] = run[i];
                pulses[i]++;
                run[i] = 0;
            end
        end
    end

    // Idle low, so the pin only moves inside a burst
    initial ext_clk = 1'b0;

    task clear_counts();
        for (int i = 0; i < 3; i++) begin
            pulses[i] = 0;
            width[i] = 0;
        end
    endtask : clear_counts

    // Slow edges, well above the three-stage synchroniser's needs
    task ext_pulses(input int n);
        repeat (n) begin
            @(posedge clk);
            #1 ext_clk = 1'b1;
            repeat (3) @(posedge clk);
            #1 ext_clk = 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask : ext_pulses
endmodule : expiry_partner
`default_nettype wire

// >>> verification/watchdog_timer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin \
    err_count++; $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
    end end
module watchdog_timer_tb_top
    import watchdog_pkg::*;
;
    logic        clk, srst, psel, penable, pwrite, pready, pslverr, ext_clk;
    logic        e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    expiry_out_t outs;
    int          err_count, checks, n;
    logic [3:0]  masks [4] = '{4'h2, 4'h4, 4'h8, 4'he};

    watchdog_timer dut_u (.clk(clk), .srst(srst), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_count_clock(ext_clk),
        .expiry_reset_out(outs.reset_out),
        .expiry_interrupt_out(outs.interrupt_out),
        .expiry_external_out(outs.external_out));

    expiry_partner partner_u (.clk(clk), .outs(outs), .ext_clk(ext_clk));

    // 25 MHz bus clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task final_report();
        $display("err_count %0d checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : final_report

    // One transfer; the answer is taken just before the access-phase edge
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        #1 psel = 1'b1;
        penable = 1'b0;
        pwrite = wr;
        paddr = a;
        pwdata = d;
        @(posedge clk);
        #1 penable = 1'b1;
        #37 q = prdata;
        e = pslverr;
        `CHK("pready", 1'b1, pready)
        @(posedge clk);
        #1 psel = 1'b0;
        penable = 1'b0;
    endtask : apb

    task rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000);
        `CHK("prdata", x, q)
    endtask : rd

    // Main sequence
    initial begin
        srst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (8) @(posedge clk);
        #1 srst = 1'b0;
        rd(COUNT_OFS, RELOAD_RESET);
        rd(RELOAD_OFS, RELOAD_RESET);
        rd(CONTROL_OFS, 32'h0000_0000);
        rd(STATUS_OFS, 32'h0000_0000);
        rd(PLEN_OFS, 32'h0000_00ff);
        apb(1'b0, 12'h020, 32'h0000_0000);
        `CHK("pslverr", 1'b1, e)
        apb(1'b1, RELOAD_OFS, 32'h0000_0014);
        apb(1'b1, RESTART_OFS, 32'h0000_1234);
        rd(COUNT_OFS, RELOAD_RESET);
        apb(1'b1, RESTART_OFS, {16'h0000, RESTART_KEY});
        rd(COUNT_OFS, 32'h0000_0014);
        rd(RESTART_OFS, 32'h0000_0000);
        // Five external edges must take exactly five off the count
        apb(1'b1, CONTROL_OFS, 32'h0000_0011);
        partner_u.ext_pulses(5);
        apb(1'b1, CONTROL_OFS, 32'h0000_0000);
        rd(COUNT_OFS, 32'h0000_000f);
        rd(COUNT_OFS, 32'h0000_000f);
        apb(1'b1, PLEN_OFS, 32'h0000_0003);
        // Each output alone, then all three together
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, CONTROL_OFS, 32'h0000_0000);
            apb(1'b1, RESTART_OFS, {16'h0000, RESTART_KEY});
            partner_u.clear_counts();
            apb(1'b1, CONTROL_OFS, {28'h000_0000, masks[k] | 4'h1});
            // Sample between edges, where the outputs are settled
            for (n = 0; n < 200 && outs === 3'b000; n++) @(negedge clk);
            if (n == 200) begin
                err_count++;
                break;
            end
            repeat (20) @(posedge clk);
            for (int i = 0; i < 3; i++) begin
                `CHK("pulses", int'(masks[k][3-i]), partner_u.pulses[i])
                if (masks[k][3-i]) `CHK("width", 4, partner_u.width[i])
            end
            rd(STATUS_OFS, 32'h0000_0001);
            rd(COUNT_OFS, 32'h0000_0000);
            apb(1'b1, CLEAR_OFS, 32'h0000_0000);
            rd(STATUS_OFS, 32'h0000_0001);
            apb(1'b1, CLEAR_OFS, 32'h0000_0001);
            rd(STATUS_OFS, 32'h0000_0000);
        end
        final_report();
    end
endmodule : watchdog_timer_tb_top
`default_nettype wire
